// ### src/four_channel_trace_capture.sv
// four-channel trace recorder: sampling, trigger, record memory, stream out
// assumes status sources and digital inputs are synchronous to clk_in

// Contract
// - triggered modes map each time base to a sample period and ten divisions
// - streaming takes 200 samples per division, 2000 per channel, 2 ms to 1 s
// - any setting change while recording aborts and restarts with new settings
// - sources assigned in order without gaps; otherwise refuse a start command (a setting-change restart skips the check)
// - channel reset command clears all settings of that channel
// - trigger from one chosen channel, DC/AC/digital, rising or falling edge
// - digital mask bit n selects digital input n
// - several mask bits: condition true only when all selected inputs active
// - digital trigger has no level; pretrigger still applies
// - after trigger keep storing until record complete, then allow readout
// - bit-track view shows 16 bits by default, limited by display mask
// - repeating mode re-arms after each record; one-shot records once
// - streaming passes samples on without trigger; others store then upload
module four_channel_trace_capture #(
  parameter int TICK_CYCLES = trace_pkg::TICK_CYCLES,
  parameter int MEM_DEPTH   = trace_pkg::MAX_REC,
  parameter int FIFO_DEPTH  = 8
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // register bus
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // observed signals
  input  wire logic [127:0] src_bus_in,
  input  wire logic [7:0]   digital_in,
  // sample stream
  output logic      [63:0] stream_data_out,
  output logic             stream_valid_out,
  input  wire logic        stream_ready_in,
  // status
  output logic             capture_busy_out,
  output logic             record_ready_out
);
  localparam int DW = trace_pkg::DATA_W;
  typedef enum logic [2:0] {S_IDLE, S_PRE, S_ARMED, S_POST, S_DONE, S_ROLL} state_e;

  // ==========================================================
  // helpers
  function automatic logic [DW-1:0] pick_src(input logic [127:0] bus, input logic [2:0] sel);
    return bus[sel*DW +: DW];
  endfunction

  function automatic logic [10:0] wrap_inc(input logic [10:0] v, input logic [10:0] len);
    return (v + 11'd1 >= len) ? 11'd0 : v + 11'd1;
  endfunction

  // ==========================================================
  // configuration registers
  trace_pkg::mode_e      mode;
  logic [3:0]            base;
  logic [1:0]            trig_ch;
  trace_pkg::trig_mode_e trig_mode;
  logic                  rising;
  logic [10:0]           pretrig;
  logic [DW-1:0]         level;
  logic [7:0]            dmask;
  logic [2:0]            ch_src   [4];
  logic [3:0]            ch_asg;
  logic [3:0]            ch_dig;
  logic [DW-1:0]         ch_view  [4];
  logic [14:0]           raddr;
  logic                  refused;
  logic [7:0]            rec_count;

  // ==========================================================
  // bus decode: one wait cycle, then the edge that completes the access
  logic ack;
  wire  req      = avs_read_in | avs_write_in;
  wire  wr_take  = avs_write_in & ack;
  wire  is_ctrl  = (avs_address_in == trace_pkg::OFS_CTRL);
  wire  is_trig  = (avs_address_in == trace_pkg::OFS_TRIG);
  wire  is_level = (avs_address_in == trace_pkg::OFS_LEVEL);
  wire  is_dmask = (avs_address_in == trace_pkg::OFS_DMASK);
  wire  is_chan  = (avs_address_in[7:4] == trace_pkg::OFS_CH0[7:4])
                   && (avs_address_in[1:0] == 2'b00);
  wire  [1:0] wch = avs_address_in[3:2];
  wire  wr_cfg  = wr_take & (is_trig | is_level | is_dmask | is_chan
                  | (is_ctrl & ~avs_writedata_in[trace_pkg::CTRL_STOP]));
  wire  wr_start = wr_take & is_ctrl & avs_writedata_in[trace_pkg::CTRL_START];
  wire  wr_stop  = wr_take & is_ctrl & avs_writedata_in[trace_pkg::CTRL_STOP];
  assign avs_waitrequest_out = req & ~ack;

  // ==========================================================
  // sequencer state
  state_e      state;
  logic [10:0] wp;
  logic [10:0] cnt;
  logic [10:0] rstart;
  logic        prev_hit;
  logic        pend;
  logic [DW-1:0] ac_mean;
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt;
  logic [13:0] per_cnt;

  wire running = (state == S_PRE) || (state == S_ARMED) || (state == S_POST)
                 || (state == S_ROLL);
  wire roll    = (mode == trace_pkg::M_ROLL);
  wire [1:0] wr_mode = avs_writedata_in[trace_pkg::CTRL_MODE_LSB +: 2];
  wire roll_next = (wr_cfg & is_ctrl) ? (wr_mode == 2'(trace_pkg::M_ROLL)) : roll;
  wire [13:0] period = trace_pkg::period_ticks(roll, base);
  wire [10:0] len    = trace_pkg::rec_len(roll, base);
  wire [10:0] pre_eff = (pretrig >= len) ? len - 11'd1 : pretrig;

  // ascending, gap-free source assignment
  wire order_ok = ch_asg[0] & ~(ch_asg[2] & ~ch_asg[1]) & ~(ch_asg[3] & ~ch_asg[2]);
  wire trig_ok  = (mode == trace_pkg::M_AUTO) || roll || ch_asg[trig_ch];
  wire start_ok = order_ok & trig_ok;

  // ==========================================================
  // sample timing
  wire tick = (tick_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES-1));
  // streaming sample waits while the buffer is full
  wire samp = tick & (per_cnt + 14'd1 >= period) & ~pend & running;

  logic [DW-1:0] chval [4];
  for (genvar c = 0; c < 4; c++) begin : g_ch
    assign chval[c] = ch_asg[c] ? pick_src(src_bus_in, ch_src[c]) : '0;
  end
  wire [63:0] sample = {chval[3], chval[2], chval[1], chval[0]};

  // ==========================================================
  // trigger condition
  wire [DW-1:0] tval   = chval[trig_ch];
  wire [DW-1:0] ac_val = tval - ac_mean;
  wire an_hit = (trig_mode == trace_pkg::T_AC) ? ($signed(ac_val) >= $signed(level))
                                               : ($signed(tval) >= $signed(level));
  // every selected input must be active, no level used
  wire dg_hit = (dmask != 8'h00) && ((digital_in & dmask) == dmask);
  wire hit    = (trig_mode == trace_pkg::T_DG) ? dg_hit : an_hit;
  wire fire   = rising ? (hit & ~prev_hit) : (~hit & prev_hit);

  // ==========================================================
  // record memory
  logic [63:0] mem [MEM_DEPTH];
  wire  [10:0] ridx  = raddr[10:0] + rstart;
  wire  [10:0] rphys = (ridx >= len) ? ridx - len : ridx;
  wire  [1:0]  rch   = raddr[trace_pkg::RADDR_CH_LSB +: 2];
  wire  [63:0] rword = mem[rphys];
  wire  [DW-1:0] rlane = rword[rch*DW +: DW];
  // bit-track channels only show the masked bits
  wire  [DW-1:0] rview = ch_dig[rch] ? (rlane & ch_view[rch]) : rlane;
  wire  [31:0] rd_mem = (state == S_DONE) ? {16'h0000, rview} : 32'h0;

  always_ff @(posedge clk_in) begin
    if (samp) begin
      mem[wp] <= sample;
    end
  end

  // ==========================================================
  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address_in)
      trace_pkg::OFS_CTRL:   rd_mux = {24'h0, base, 2'(mode), 2'b00};
      trace_pkg::OFS_TRIG:   rd_mux = {5'h0, pretrig, 11'h0, rising, 2'(trig_mode), trig_ch};
      trace_pkg::OFS_LEVEL:  rd_mux = {16'h0, level};
      trace_pkg::OFS_DMASK:  rd_mux = {24'h0, dmask};
      trace_pkg::OFS_STATUS: rd_mux = {8'h0, rec_count, 7'h0, refused, 5'h0, 3'(state)};
      trace_pkg::OFS_RADDR:  rd_mux = {17'h0, raddr};
      trace_pkg::OFS_RDATA:  rd_mux = rd_mem;
      default: begin
        if (is_chan) begin
          rd_mux = {ch_view[wch], 10'h0, ch_dig[wch], ch_asg[wch], 1'b0, ch_src[wch]};
        end
      end
    endcase
  end

  // ==========================================================
  // bus handshake and read data
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack              <= 1'b0;
      avs_readdata_out <= 32'h0;
    end else begin
      ack <= req & ~ack;
      if (avs_read_in & ~ack) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end

  // ==========================================================
  // configuration writes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode      <= trace_pkg::M_SINGLE;
      base      <= trace_pkg::BASE_RST;
      trig_ch   <= 2'd0;
      trig_mode <= trace_pkg::T_DC;
      rising    <= 1'b1;
      pretrig   <= 11'd0;
      level     <= '0;
      dmask     <= trace_pkg::DMASK_RST;
      raddr     <= '0;
      ch_asg    <= 4'h0;
      ch_dig    <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        ch_src[i]  <= 3'd0;
        ch_view[i] <= trace_pkg::DISP_MASK_RST;
      end
    end else if (wr_take) begin
      if (is_ctrl && !avs_writedata_in[trace_pkg::CTRL_STOP]) begin
        mode <= trace_pkg::mode_e'(avs_writedata_in[trace_pkg::CTRL_MODE_LSB +: 2]);
        base <= avs_writedata_in[trace_pkg::CTRL_BASE_LSB +: 4];
      end
      if (is_trig) begin
        trig_ch   <= avs_writedata_in[trace_pkg::TRIG_CH_LSB +: 2];
        trig_mode <= trace_pkg::trig_mode_e'(avs_writedata_in[trace_pkg::TRIG_MODE_LSB +: 2]);
        rising    <= avs_writedata_in[trace_pkg::TRIG_RISE];
        pretrig   <= avs_writedata_in[trace_pkg::TRIG_PRE_LSB +: 11];
      end
      if (is_level) begin
        level <= avs_writedata_in[DW-1:0];
      end
      if (is_dmask) begin
        dmask <= avs_writedata_in[7:0];
      end
      if (avs_address_in == trace_pkg::OFS_RADDR) begin
        raddr <= avs_writedata_in[14:0];
      end
      if (is_chan) begin
        if (avs_writedata_in[trace_pkg::CH_CLEAR]) begin
          ch_src[wch]  <= 3'd0;
          ch_asg[wch]  <= 1'b0;
          ch_dig[wch]  <= 1'b0;
          ch_view[wch] <= trace_pkg::DISP_MASK_RST;
        end else begin
          ch_src[wch]  <= avs_writedata_in[trace_pkg::CH_SRC_LSB +: 3];
          ch_asg[wch]  <= avs_writedata_in[trace_pkg::CH_ASSIGNED];
          ch_dig[wch]  <= avs_writedata_in[trace_pkg::CH_VIEW_DIG];
          ch_view[wch] <= avs_writedata_in[trace_pkg::CH_DMASK_LSB +: DW];
        end
      end
    end
  end

  // ==========================================================
  // time base counters
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt <= '0;
      per_cnt  <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (!running || wr_cfg) begin
        per_cnt <= '0;
      end else if (tick && !pend) begin
        per_cnt <= (per_cnt + 14'd1 >= period) ? 14'd0 : per_cnt + 14'd1;
      end
    end
  end

  // ==========================================================
  // recording sequencer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state     <= S_IDLE;
      wp        <= '0;
      cnt       <= '0;
      rstart    <= '0;
      prev_hit  <= 1'b0;
      ac_mean   <= '0;
      refused   <= 1'b0;
      rec_count <= '0;
    end else begin
      if (wr_stop) begin
        state <= (state == S_DONE) ? S_DONE : S_IDLE;
      end else if (wr_start || (running && wr_cfg)) begin
        // new settings take effect from a clean record
        wp  <= '0;
        cnt <= '0;
        if (start_ok || !wr_start) begin
          refused <= 1'b0;
          state   <= roll_next ? S_ROLL : S_PRE;
        end else begin
          refused <= 1'b1;
          state   <= S_IDLE;
        end
      end else if (samp) begin
        prev_hit <= hit;
        ac_mean  <= ac_mean + DW'($signed(tval - ac_mean) >>> trace_pkg::AC_SHIFT);
        wp       <= wrap_inc(wp, len);
        case (state)
          S_PRE: begin
            cnt <= cnt + 11'd1;
            if (cnt + 11'd1 >= pre_eff) begin
              cnt   <= '0;
              state <= (mode == trace_pkg::M_AUTO) ? S_POST : S_ARMED;
            end
          end
          S_ARMED: begin
            if (fire) begin
              cnt   <= 11'd1;
              state <= S_POST;
            end
          end
          S_POST: begin
            cnt <= cnt + 11'd1;
            if (cnt + 11'd1 >= len - pre_eff) begin
              rstart    <= wrap_inc(wp, len);
              rec_count <= rec_count + 8'd1;
              state     <= S_DONE;
            end
          end
          S_ROLL: begin
            cnt <= wrap_inc(cnt, len);
          end
          default: begin
            state <= state;
          end
        endcase
      end else if (state == S_DONE && mode == trace_pkg::M_NORMAL && tick) begin
        wp    <= '0;
        cnt   <= '0;
        state <= S_PRE;
      end
    end
  end

  // ==========================================================
  // streaming path, stalls sampling while the buffer is full
  trace_fifo_if #(.WIDTH(64)) sif ();
  logic [63:0] pend_data;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend      <= 1'b0;
      pend_data <= '0;
    end else begin
      if (samp && state == S_ROLL) begin
        pend      <= 1'b1;
        pend_data <= sample;
      end else if (sif.in_ready || state != S_ROLL) begin
        pend <= 1'b0;
      end
    end
  end

  assign sif.in_data   = pend_data;
  assign sif.in_valid  = pend & (state == S_ROLL);
  assign sif.out_ready = stream_ready_in;

  trace_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .f         (sif)
  );

  assign stream_data_out  = sif.out_data;
  assign stream_valid_out = sif.out_valid;
  assign capture_busy_out = running;
  assign record_ready_out = (state == S_DONE);
endmodule // four_channel_trace_capture

// ### src/trace_fifo.sv
// synchronous first-word-fall-through buffer for streamed samples
// assumes one clock and an asynchronous active-low reset
module trace_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic    clk_in,
  input  wire logic    arst_n_in,
  trace_fifo_if.buffer f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rp;
  logic [AW-1:0]    wp;
  logic [AW:0]      level;

  wire push = f.in_valid & f.in_ready;
  wire pop  = f.out_valid & f.out_ready;

  assign f.in_ready  = (level != (AW+1)'(DEPTH));
  assign f.out_valid = (level != '0);
  assign f.out_data  = mem[rp];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp] <= f.in_data;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rp    <= '0;
      wp    <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // trace_fifo

// ### src/trace_fifo_if.sv
// handshake bundle between the recorder core and its stream buffer
// assumes both ends sit on the same clock
interface trace_fifo_if #(parameter int WIDTH = 64);
  logic [WIDTH-1:0] in_data;
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] out_data;
  logic             out_valid;
  logic             out_ready;

  modport buffer (input in_data, in_valid, out_ready,
                  output in_ready, out_data, out_valid);
  modport user   (output in_data, in_valid, out_ready,
                  input in_ready, out_data, out_valid);
endinterface

// ### src/trace_pkg.sv
// constants, register map and time-base tables of the trace recorder
// assumes a 20 MHz system clock and 32-bit word-aligned register access
package trace_pkg;

  // ==========================================================
  // widths and timing
  localparam int DATA_W       = 16;
  localparam int NUM_CH       = 4;
  localparam int NUM_SRC      = 8;
  localparam int DIG_W        = 8;
  localparam int CLK_MHZ      = 20;
  localparam int TICK_US      = 125;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
  localparam int DIVS         = 10;
  localparam int ROLL_PER_DIV = 200;
  localparam int MAX_REC      = 2000;
  localparam int AC_SHIFT     = 4;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TRIG   = 8'h04;
  localparam logic [7:0] OFS_LEVEL  = 8'h08;
  localparam logic [7:0] OFS_DMASK  = 8'h0c;
  localparam logic [7:0] OFS_CH0    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_RADDR  = 8'h24;
  localparam logic [7:0] OFS_RDATA  = 8'h28;

  // ==========================================================
  // field positions
  localparam int CTRL_START    = 0;
  localparam int CTRL_STOP     = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_BASE_LSB = 4;
  localparam int TRIG_CH_LSB   = 0;
  localparam int TRIG_MODE_LSB = 2;
  localparam int TRIG_RISE     = 4;
  localparam int TRIG_PRE_LSB  = 16;
  localparam int CH_SRC_LSB    = 0;
  localparam int CH_ASSIGNED   = 4;
  localparam int CH_VIEW_DIG   = 5;
  localparam int CH_CLEAR      = 8;
  localparam int CH_DMASK_LSB  = 16;
  localparam int RADDR_CH_LSB  = 12;
  localparam int ST_REFUSED    = 8;
  localparam int ST_COUNT_LSB  = 16;

  // ==========================================================
  // reset values
  localparam logic [15:0] DISP_MASK_RST = 16'hffff;
  localparam logic [7:0]  DMASK_RST     = 8'h01;
  localparam logic [3:0]  BASE_RST      = 4'h0;

  typedef enum logic [1:0] {M_SINGLE, M_NORMAL, M_AUTO, M_ROLL} mode_e;
  typedef enum logic [1:0] {T_DC, T_AC, T_DG} trig_mode_e;

  // ==========================================================
  // time-base tables, periods in 125 us ticks
  function automatic logic [13:0] period_ticks(input logic roll, input logic [3:0] base);
    logic [13:0] t;
    t = 14'h0001;
    if (roll) begin
      case (base)
        4'h0:    t = 14'd16;
        4'h1:    t = 14'd40;
        4'h2:    t = 14'd80;
        4'h3:    t = 14'd160;
        4'h4:    t = 14'd400;
        4'h5:    t = 14'd800;
        4'h6:    t = 14'd1600;
        4'h7:    t = 14'd4000;
        default: t = 14'd8000;
      endcase
    end else begin
      case (base)
        4'h5, 4'h6: t = 14'd8;
        4'h7:       t = 14'd16;
        4'h8:       t = 14'd20;
        4'h9:       t = 14'd80;
        4'ha:       t = 14'd100;
        4'hb:       t = 14'd200;
        4'hc:       t = 14'd500;
        4'hd, 4'he, 4'hf: t = 14'd1000;
        default:    t = 14'd1;
      endcase
    end
    return t;
  endfunction

  function automatic logic [10:0] rec_len(input logic roll, input logic [3:0] base);
    logic [7:0] d;
    d = 8'd80;
    if (roll) begin
      d = 8'(ROLL_PER_DIV);
    end else begin
      case (base)
        4'h0:             d = 8'd4;
        4'h1:             d = 8'd8;
        4'h2:             d = 8'd16;
        4'h3:             d = 8'd40;
        4'h5:             d = 8'd20;
        4'h6, 4'h7, 4'h9: d = 8'd50;
        default:          d = 8'd80;
      endcase
    end
    return 11'(d * DIVS);
  endfunction

endpackage

// ### testbench/stream_consumer.sv
// far-side model: host tool taking streamed samples, able to stall
// assumes the stream handshake of the recorder on the same clock
module stream_consumer (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // stream
  input  wire logic [63:0] data_in,
  input  wire logic        valid_in,
  input  wire logic        stall_in,
  output logic             ready_out,
  output logic      [15:0] words_out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_out <= 1'b0;
      words_out <= 16'h0;
    end else begin
      ready_out <= !stall_in;
      if (valid_in && ready_out) begin
        words_out <= words_out + 16'h1;
      end
    end
  end
endmodule // stream_consumer

// ### testbench/testbench.sv
// self-checking bench of the trace recorder with a stalling stream consumer
// assumes a 50 ns clock and a shortened 4-cycle sample tick
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] e;} row_s;
  logic          clk_in = 1'b0;
  logic          arst_n_in = 1'b0;
  logic          rd = 1'b0;
  logic          wr = 1'b0;
  logic          stall = 1'b0;
  logic [7:0]    adr = 8'h0;
  logic [31:0]   wd = 32'h0;
  logic [31:0]   rdata;
  logic          waitreq;
  logic [7:0]    din = 8'h0;
  logic [63:0]   sdata;
  logic          svalid;
  logic          sready;
  logic          busy;
  logic          ready;
  logic [15:0]   words;
  logic [31:0]   q;
  int            n_errors = 0;
  int            comparisons = 0;
  int            cycles = 0;
  time           t0;
  time           t1;
  row_s          rows [8] = '{'{8'h0c, 32'h1}, '{8'h10, 32'hffff0000}, '{8'h14, 32'hffff0000},
    '{8'h18, 32'hffff0000}, '{8'h1c, 32'hffff0000}, '{8'h20, 32'h0}, '{8'h28, 32'h0},
    '{8'h30, 32'h0}};
  four_channel_trace_capture #(.TICK_CYCLES(4)) DUT (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .src_bus_in({112'h0, 16'h1234}), .digital_in(din),
    .stream_data_out(sdata), .stream_valid_out(svalid), .stream_ready_in(sready),
    .capture_busy_out(busy), .record_ready_out(ready));
  stream_consumer u_pc (.clk_in(clk_in), .arst_n_in(arst_n_in), .data_in(sdata),
    .valid_in(svalid), .stall_in(stall), .ready_out(sready), .words_out(words));
  always #25 clk_in = ~clk_in;
  // ==========================================================
  // tasks
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // request held until waitrequest seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_in); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic take(output time t);
    do @(negedge clk_in); while (!(svalid === 1'b1 && sready === 1'b1));
    t = $time;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      `CHK(q, rows[i].e)
    end
    bus(1'b1, 8'h14, 32'h00000011);
    bus(1'b1, 8'h00, 32'h00000001);
    bus(1'b0, 8'h20, 32'h0);
    `CHK(q[8], 1'b1)
    `CHK(busy, 1'b0)
    bus(1'b1, 8'h14, 32'h00000100);
    bus(1'b0, 8'h14, 32'h0);
    `CHK(q, 32'hffff0000)
    // mask 64h: inputs 2, 5 and 6 together
    bus(1'b1, 8'h10, 32'h00000010);
    bus(1'b1, 8'h04, 32'h00000018);
    bus(1'b1, 8'h0c, 32'h00000064);
    bus(1'b0, 8'h0c, 32'h0);
    `CHK(q, 32'h64)
    bus(1'b1, 8'h00, 32'h00000001);
    din <= 8'h24;
    repeat (200) @(posedge clk_in);
    `CHK(ready, 1'b0)
    din <= 8'hff;
    repeat (80) @(posedge clk_in);
    // level write mid-record restarts it; input stays high, so no new edge
    bus(1'b1, 8'h08, 32'h0);
    repeat (200) @(posedge clk_in);
    `CHK(ready, 1'b0)
    din <= 8'h00;
    repeat (20) @(posedge clk_in);
    din <= 8'hff;
    repeat (400) @(posedge clk_in);
    `CHK(ready, 1'b1)
    bus(1'b0, 8'h20, 32'h0);
    `CHK(q, 32'h00010004)
    bus(1'b1, 8'h24, 32'h00000005);
    bus(1'b0, 8'h28, 32'h0);
    `CHK(q, 32'h00001234)
    bus(1'b1, 8'h10, 32'h00ff0030);
    bus(1'b0, 8'h28, 32'h0);
    `CHK(q, 32'h00000034)
    // streaming: base 0 is 16 ticks of 4 cycles
    bus(1'b1, 8'h00, 32'h0000000d);
    take(t0);
    `CHK(sdata, 64'h1234)
    take(t1);
    `CHK(t1 - t0, 64 * 50)
    `CHK(words, 16'h1)
    stall <= 1'b1;
    repeat (700) @(posedge clk_in);
    `CHK(svalid, 1'b1)
    bus(1'b1, 8'h00, 32'h0000001c);
    `CHK(busy, 1'b1)
    stall <= 1'b0;
    bus(1'b1, 8'h00, 32'h00000002);
    repeat (30) @(posedge clk_in);
    `CHK(svalid, 1'b0)
    `CHK(busy, 1'b0)
    // repeating mode re-arms after its record, so the state is armed again
    bus(1'b1, 8'h00, 32'h00000005);
    din <= 8'h00;
    repeat (20) @(posedge clk_in);
    din <= 8'hff;
    repeat (200) @(posedge clk_in);
    bus(1'b0, 8'h20, 32'h0);
    `CHK(q, 32'h00020002)
    // auto: no trigger, 40 samples of 4 cycles for base 0
    bus(1'b1, 8'h00, 32'h00000009);
    repeat (150) @(posedge clk_in);
    `CHK(ready, 1'b0)
    repeat (20) @(posedge clk_in);
    `CHK(ready, 1'b1)
    print_verdict();
  end
endmodule // testbench

// ### testbench/trace_capture_assertions.sv
// checker: bus, stream and status relations at the recorder's ports
// assumes one clock domain and an asynchronous active-low reset
module trace_capture_assertions (
  input wire logic         clk_in,
  input wire logic         arst_n_in,
  input wire logic [7:0]   avs_address_in,
  input wire logic         avs_read_in,
  input wire logic         avs_write_in,
  input wire logic [31:0]  avs_writedata_in,
  input wire logic [31:0]  avs_readdata_out,
  input wire logic         avs_waitrequest_out,
  input wire logic [127:0] src_bus_in,
  input wire logic [7:0]   digital_in,
  input wire logic [63:0]  stream_data_out,
  input wire logic         stream_valid_out,
  input wire logic         stream_ready_in,
  input wire logic         capture_busy_out,
  input wire logic         record_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ==========================================================
  // register bus
  sequence s_one_wait;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  sequence s_done_rd(logic [7:0] a);
    avs_read_in && !avs_waitrequest_out && avs_address_in == a;
  endsequence
  AST_WAIT_ONE: assert property ($rose(avs_read_in || avs_write_in) |-> s_one_wait)
    else $error("access did not finish after one wait cycle");
  AST_NO_IDLE_WAIT: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("wait raised without a request");
  AST_UNMAPPED_ZERO: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in >= 8'h2c |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_RDATA_EMPTY: assert property (s_done_rd(8'h28) and !$past(record_ready_out)
    |-> avs_readdata_out == 32'h0)
    else $error("record data readable before record complete");
  AST_STATUS_DONE: assert property (s_done_rd(8'h20) and $past(record_ready_out)
    |-> avs_readdata_out[2:0] == 3'h4)
    else $error("status state not done while record held");
  AST_STATUS_IDLE: assert property (s_done_rd(8'h20) and !$past(record_ready_out)
    and !$past(capture_busy_out) |-> avs_readdata_out[2:0] == 3'h0)
    else $error("status state not idle");
  // ==========================================================
  // stream and status
  AST_STREAM_HOLD: assert property (stream_valid_out && !stream_ready_in
    |=> stream_valid_out && $stable(stream_data_out))
    else $error("stream word lost while stalled");
  AST_DONE_IDLE: assert property (record_ready_out |-> !capture_busy_out)
    else $error("busy while record held");
endmodule // trace_capture_assertions

bind four_channel_trace_capture trace_capture_assertions u_chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .src_bus_in(src_bus_in), .digital_in(digital_in), .stream_data_out(stream_data_out),
  .stream_valid_out(stream_valid_out), .stream_ready_in(stream_ready_in),
  .capture_busy_out(capture_busy_out), .record_ready_out(record_ready_out));
